// ### hdl/scc_pkg.sv
// Purpose: shared constants for the sync, reference and clock configuration slice
// Assumes: serial frame of one read flag, seven address bits and eight data bits
// Notes: register offsets are byte addresses on the serial configuration port
package scc_pkg;
  localparam logic [6:0] SCC_OFS_SYNC_REF  = 7'h0e;
  localparam logic [6:0] SCC_OFS_INPUT     = 7'h11;
  localparam logic [6:0] SCC_OFS_FUSE      = 7'h13;
  // field positions, sync/reference register
  localparam int         SCC_B_PIN_ROLE    = 7;
  localparam int         SCC_B_ALIGN_TRIG  = 6;
  localparam int         SCC_B_ALIGN_EN    = 5;
  localparam int         SCC_B_VREF_ORIG   = 3;
  localparam int         SCC_B_VREF_LSB    = 1;
  localparam int         SCC_B_SE_CLK      = 0;
  // field positions, input and fuse registers
  localparam int         SCC_B_UNBAL_A     = 5;
  localparam int         SCC_B_UNBAL_B     = 4;
  localparam int         SCC_B_DLL_OFF     = 2;
  localparam int         SCC_B_NULLING     = 0;
  localparam int         SCC_B_FUSE_LOAD   = 0;
  // values after reset
  localparam logic [7:0] SCC_RST_SYNC_REF  = 8'h00;
  localparam logic [7:0] SCC_RST_INPUT     = 8'h00;
  localparam logic [7:0] SCC_RST_FUSE      = 8'h00;
  // writable masks, reserved bits read zero
  localparam logic [7:0] SCC_MSK_SYNC_REF  = 8'hef;
  localparam logic [7:0] SCC_MSK_INPUT     = 8'h35;
  localparam logic [7:0] SCC_MSK_FUSE      = 8'h01;
  // vref source encodings
  localparam logic [1:0] SCC_VREF_INT      = 2'h0;
  localparam logic [1:0] SCC_VREF_EXT_BUF  = 2'h1;
  localparam logic [1:0] SCC_VREF_EXT_DIR  = 2'h2;
  // serial frame geometry
  localparam logic [3:0] SCC_CMD_BITS      = 4'h8;
  localparam logic [3:0] SCC_LAST_BIT      = 4'hf;
  localparam int         SCC_SYNC_STAGES   = 3;
endpackage : scc_pkg

// ### hdl/scc_cfg_if.sv
// Purpose: register access carrier between serial front end and register slice
// Assumes: one core clock for both ends
// Notes: rdata is combinational from the register slice
interface scc_cfg_if;
  logic       wr_stb;
  logic [6:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  modport serial (output wr_stb, output addr, output wdata, input rdata);
  modport regs   (input wr_stb, input addr, input wdata, output rdata);
endinterface : scc_cfg_if

// ### hdl/scc_serial_port.sv
// Purpose: serial configuration slave, oversampled on the core clock
// Assumes: serial clock below one eighth of the core clock, mode 0, MSB first
// Notes: frame is read flag, 7 address bits, 8 data bits; sdout changes on falling edges
module scc_serial_port
  import scc_pkg::*;
(
  // clock and reset
  input  wire logic core_clk_i,
  input  wire logic resetn_i,
  // serial pins
  input  wire logic sclk_i,
  input  wire logic sen_n_i,
  input  wire logic sdio_i,
  output logic      sdout_o,
  // register side
  scc_cfg_if.serial cfg
);
  logic [2:0] s1_q, s2_q, s3_q, flt_q, flt_d;
  logic [3:0] cnt_q;
  logic       rd_q;
  logic [7:0] sh_in_q, sh_out_q;
  logic       rise, fall, sel;

  // a pin change counts once the two late stages agree
  assign flt_d = (s2_q ~^ s3_q) & s3_q | ~(s2_q ~^ s3_q) & flt_q;
  assign rise  = flt_d[0] & ~flt_q[0];
  assign fall  = ~flt_d[0] & flt_q[0];
  assign sel   = ~flt_q[1];

  // three-stage synchronisers for sclk, sen_n and sdio
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s1_q  <= 3'h2;
      s2_q  <= 3'h2;
      s3_q  <= 3'h2;
      flt_q <= 3'h2;
    end else begin
      s1_q  <= {sdio_i, sen_n_i, sclk_i};
      s2_q  <= s1_q;
      s3_q  <= s2_q;
      flt_q <= flt_d;
    end
  end

  // bit counter and shifters; deselect aborts a partial frame
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cnt_q      <= 4'h0;
      rd_q       <= 1'b0;
      sh_in_q    <= 8'h00;
      sh_out_q   <= 8'h00;
      sdout_o    <= 1'b0;
      cfg.wr_stb <= 1'b0;
      cfg.addr   <= 7'h00;
      cfg.wdata  <= 8'h00;
    end else begin
      cfg.wr_stb <= 1'b0;
      if (!sel) begin
        cnt_q   <= 4'h0;
        sdout_o <= 1'b0;
      end else if (rise) begin
        cnt_q   <= cnt_q + 4'h1;
        sh_in_q <= {sh_in_q[6:0], flt_q[2]};
        if (cnt_q == SCC_CMD_BITS - 4'h1) begin
          rd_q     <= sh_in_q[6];
          cfg.addr <= {sh_in_q[5:0], flt_q[2]};
        end
        if (cnt_q == SCC_LAST_BIT && !rd_q) begin
          cfg.wdata  <= {sh_in_q[6:0], flt_q[2]};
          cfg.wr_stb <= 1'b1;
        end
      end else if (fall && rd_q && cnt_q >= SCC_CMD_BITS) begin
        // read data is captured at the first falling edge after the address
        if (cnt_q == SCC_CMD_BITS) begin
          sdout_o  <= cfg.rdata[7];
          sh_out_q <= {cfg.rdata[6:0], 1'b0};
        end else begin
          sdout_o  <= sh_out_q[7];
          sh_out_q <= {sh_out_q[6:0], 1'b0};
        end
      end
    end
  end
endmodule : scc_serial_port

// ### hdl/scc_top.sv
// Purpose: sync, reference, clock and input configuration registers with their effects
// Assumes: shared align/powerdown pin and buffer pin are asynchronous to core_clk_i
// Notes: FAST_VARIANT selects the highest-rate variant behaviour
module scc_top
  import scc_pkg::*;
#(
  parameter bit FAST_VARIANT = 1'b0
) (
  // clock and reset
  input  wire logic       core_clk_i,
  input  wire logic       resetn_i,
  // serial configuration pins
  input  wire logic       sclk_i,
  input  wire logic       sen_n_i,
  input  wire logic       sdio_i,
  output logic            sdout_o,
  // control pins
  input  wire logic       shared_align_powerdown_pin_i,
  input  wire logic       reference_buffer_pin_i,
  // power and sync
  output logic            global_powerdown_o,
  output logic            align_pulse_o,
  // reference and clock
  output logic [1:0]      vref_source_o,
  output logic            vref_unused_o,
  output logic            single_ended_clock_o,
  output logic            diff_clkbuf_off_o,
  // analog front end
  output logic            unbalanced_input_a_o,
  output logic            unbalanced_input_b_o,
  output logic            sampling_half_period_o,
  output logic            offset_nulling_on_o,
  // fuse mapping
  output logic            fuse_reload_o
);
  scc_cfg_if cfg ();

  logic [7:0] sync_ref_q, input_q, fuse_q;
  logic [2:0] pin_s_q, buf_s_q;
  logic       pin_q, buf_q;
  logic       pin_d, buf_d;
  logic       wr_sr, wr_in, wr_fu, fuse_fall;
  logic       pin_role, align_en, trig_rise, pin_rise, origin;
  logic [1:0] vref_d;

  scc_serial_port u_serial (
    .core_clk_i (core_clk_i),
    .resetn_i   (resetn_i),
    .sclk_i     (sclk_i),
    .sen_n_i    (sen_n_i),
    .sdio_i     (sdio_i),
    .sdout_o    (sdout_o),
    .cfg        (cfg.serial)
  );

  // address decode and read mux; unmapped offsets read zero
  assign wr_sr     = cfg.wr_stb && cfg.addr == SCC_OFS_SYNC_REF;
  assign wr_in     = cfg.wr_stb && cfg.addr == SCC_OFS_INPUT;
  assign wr_fu     = cfg.wr_stb && cfg.addr == SCC_OFS_FUSE;
  assign cfg.rdata = cfg.addr == SCC_OFS_SYNC_REF ? sync_ref_q :
                     cfg.addr == SCC_OFS_INPUT    ? input_q    :
                     cfg.addr == SCC_OFS_FUSE     ? fuse_q     : 8'h00;

  assign fuse_fall = wr_fu && fuse_q[SCC_B_FUSE_LOAD] && !cfg.wdata[SCC_B_FUSE_LOAD];

  // three-stage filters for the two control pins
  assign pin_d = (pin_s_q[1] == pin_s_q[2]) ? pin_s_q[2] : pin_q;
  assign buf_d = (buf_s_q[1] == buf_s_q[2]) ? buf_s_q[2] : buf_q;

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pin_s_q <= 3'h0;
      buf_s_q <= 3'h0;
      pin_q   <= 1'b0;
      buf_q   <= 1'b0;
    end else begin
      pin_s_q <= {pin_s_q[1:0], shared_align_powerdown_pin_i};
      buf_s_q <= {buf_s_q[1:0], reference_buffer_pin_i};
      pin_q   <= pin_d;
      buf_q   <= buf_d;
    end
  end

  // register storage; a fuse reload returns the others to reset
  // trigger held as written
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sync_ref_q <= SCC_RST_SYNC_REF;
      input_q    <= SCC_RST_INPUT;
      fuse_q     <= SCC_RST_FUSE;
    end else begin
      if (fuse_fall) begin
        sync_ref_q <= SCC_RST_SYNC_REF;
        input_q    <= SCC_RST_INPUT;
      end else begin
        if (wr_sr) sync_ref_q <= cfg.wdata & SCC_MSK_SYNC_REF;
        if (wr_in) input_q <= cfg.wdata & SCC_MSK_INPUT;
      end
      if (wr_fu) fuse_q <= cfg.wdata & SCC_MSK_FUSE;
    end
  end

  assign pin_role  = sync_ref_q[SCC_B_PIN_ROLE];
  assign align_en  = sync_ref_q[SCC_B_ALIGN_EN];
  assign origin    = sync_ref_q[SCC_B_VREF_ORIG];
  // trigger rises only by a write
  assign trig_rise = wr_sr && !fuse_fall && cfg.wdata[SCC_B_ALIGN_TRIG]
                     && !sync_ref_q[SCC_B_ALIGN_TRIG];
  assign pin_rise  = pin_d && !pin_q;
  // reference origin and decode; with origin bit clear, buffer pin high picks buffered external
  assign vref_d    = origin ? sync_ref_q[SCC_B_VREF_LSB +: 2]
                            : (buf_q ? SCC_VREF_EXT_BUF : SCC_VREF_INT);

  // outputs, all registered
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      global_powerdown_o     <= 1'b0;
      align_pulse_o          <= 1'b0;
      vref_source_o          <= SCC_VREF_INT;
      vref_unused_o          <= 1'b0;
      single_ended_clock_o   <= 1'b0;
      diff_clkbuf_off_o      <= 1'b0;
      unbalanced_input_a_o   <= 1'b0;
      unbalanced_input_b_o   <= 1'b0;
      sampling_half_period_o <= 1'b0;
      offset_nulling_on_o    <= !FAST_VARIANT;
      fuse_reload_o          <= 1'b0;
    end else begin
      global_powerdown_o     <= !pin_role && pin_q;
      align_pulse_o          <= align_en ? (trig_rise && cfg.wdata[SCC_B_ALIGN_EN])
                                         : (pin_role && pin_rise);
      vref_source_o          <= vref_d;
      vref_unused_o          <= &vref_d;
      single_ended_clock_o   <= origin && sync_ref_q[SCC_B_SE_CLK];
      diff_clkbuf_off_o      <= origin && sync_ref_q[SCC_B_SE_CLK];
      unbalanced_input_a_o   <= input_q[SCC_B_UNBAL_A];
      unbalanced_input_b_o   <= input_q[SCC_B_UNBAL_B];
      // delay loop only on fast variant; host keeps rate below limit
      sampling_half_period_o <= FAST_VARIANT && input_q[SCC_B_DLL_OFF];
      offset_nulling_on_o    <= FAST_VARIANT ? input_q[SCC_B_NULLING]
                                             : !input_q[SCC_B_NULLING];
      fuse_reload_o          <= fuse_fall;
    end
  end

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!resetn_i);

  property p_pd_follows_pin;
    pin_q && !pin_role |=> global_powerdown_o;
  endproperty
  a_pd_follows_pin: assert property (p_pd_follows_pin)
    else $error("power down not raised by pin");

  property p_sync_role_no_pd;
    pin_role |=> !global_powerdown_o;
  endproperty
  a_sync_role_no_pd: assert property (p_sync_role_no_pd)
    else $error("power down raised in sync role");

  property p_trig_pulse;
    trig_rise && align_en && cfg.wdata[SCC_B_ALIGN_EN] |=> align_pulse_o;
  endproperty
  a_trig_pulse: assert property (p_trig_pulse)
    else $error("register trigger gave no sync");

  property p_trig_holds;
    sync_ref_q[SCC_B_ALIGN_TRIG] && !wr_sr && !fuse_fall |=>
      sync_ref_q[SCC_B_ALIGN_TRIG];
  endproperty
  a_trig_holds: assert property (p_trig_holds)
    else $error("trigger bit cleared itself");

  property p_pin_ignored;
    align_en && !wr_sr |=> !align_pulse_o;
  endproperty
  a_pin_ignored: assert property (p_pin_ignored)
    else $error("pin sync while register sync enabled");

  property p_buf_pin_ref;
    !origin && buf_q |=> vref_source_o == SCC_VREF_EXT_BUF;
  endproperty
  a_buf_pin_ref: assert property (p_buf_pin_ref)
    else $error("buffer pin ignored");

  property p_se_clk;
    !origin |=> !single_ended_clock_o && !diff_clkbuf_off_o;
  endproperty
  a_se_clk: assert property (p_se_clk)
    else $error("single-ended clock without origin bit");

  property p_half_period;
    sampling_half_period_o |-> FAST_VARIANT && $past(input_q[SCC_B_DLL_OFF]);
  endproperty
  a_half_period: assert property (p_half_period)
    else $error("half period without delay-loop-off");

  property p_nulling;
    ##1 offset_nulling_on_o == (FAST_VARIANT ~^ $past(input_q[SCC_B_NULLING]));
  endproperty
  a_nulling: assert property (p_nulling)
    else $error("offset nulling polarity wrong");

  // each channel mode output follows its own register bit one cycle later
  property p_unbal;
    ##1 unbalanced_input_a_o == $past(input_q[SCC_B_UNBAL_A])
        && unbalanced_input_b_o == $past(input_q[SCC_B_UNBAL_B]);
  endproperty
  a_unbal: assert property (p_unbal)
    else $error("input mode does not follow register");

  property p_reload_clears;
    fuse_fall |=> fuse_reload_o && sync_ref_q == SCC_RST_SYNC_REF
                  && input_q == SCC_RST_INPUT;
  endproperty
  a_reload_clears: assert property (p_reload_clears)
    else $error("fuse reload did not clear registers");
endmodule : scc_top

// ### verif/scc_host_model.sv
// Purpose: serial configuration host for the register slice
// Assumes: mode 0 frames, 12 core cycles per serial bit
// Notes: the data line shows the inverse of its last bit once released
module scc_host_model (
  // clock
  input  wire logic core_clk_i,
  // serial pins
  output logic      sclk_o,
  output logic      sen_n_o,
  output logic      sdio_o,
  input  wire logic sdout_i
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int HALF = 6;  // above the 4-cycle filter minimum

  // idle pins before the first frame
  initial begin
    sclk_o  = 1'b0;
    sen_n_o = 1'b1;
    sdio_o  = 1'b0;
  end

  // one frame; sdout sampled late in the high phase, long after it settles
  // zero reserved bits: callers pass zeros except when probing masks
  task automatic xfer(input logic rd, input logic [6:0] a, input logic [7:0] wd,
                      output logic [7:0] rdat);
    logic [15:0] frame;
    frame = {rd, a, wd};
    rdat = 8'h00;
    sen_n_o <= 1'b0;
    repeat (HALF) @(posedge core_clk_i);
    for (int i = 15; i >= 0; i--) begin
      sdio_o <= frame[i];
      repeat (HALF) @(posedge core_clk_i);
      sclk_o <= 1'b1;
      repeat (HALF) @(posedge core_clk_i);
      if (i < 8) rdat[i] = sdout_i;
      sclk_o <= 1'b0;
    end
    repeat (HALF) @(posedge core_clk_i);
    sen_n_o <= 1'b1;
    sdio_o  <= ~frame[0];
    repeat (HALF) @(posedge core_clk_i);
  endtask : xfer
endmodule : scc_host_model

// ### verif/tb_converter_sync_ref_clock_config.sv
// Purpose: self-checking bench for the sync, reference and input registers
// Assumes: a slow and a fast variant share every input
// Notes: pulses are counted by monitors, scenarios compare count deltas
module tb_converter_sync_ref_clock_config
  import scc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic       core_clk_i = 1'b0;
  logic       resetn_i   = 1'b0;
  logic       pin_sh     = 1'b0;
  logic       pin_rb     = 1'b0;
  wire        sclk, sen_n, sdio, sdout, pdn, algn, vun, sec, cbo, ua, ub, h0, h1, n0, n1, frl;
  wire  [1:0] vsrc;
  int         failures   = 0;
  int         cmp_count  = 0;
  int         a_cnt      = 0;
  int         f_cnt      = 0;
  int         base;
  logic [7:0] rd;

  // free-running core clock
  always #5 core_clk_i = ~core_clk_i;

  scc_top #(.FAST_VARIANT(1'b0)) DUT (.core_clk_i(core_clk_i), .resetn_i(resetn_i),
    .sclk_i(sclk), .sen_n_i(sen_n), .sdio_i(sdio), .sdout_o(sdout),
    .shared_align_powerdown_pin_i(pin_sh), .reference_buffer_pin_i(pin_rb),
    .global_powerdown_o(pdn), .align_pulse_o(algn), .vref_source_o(vsrc),
    .vref_unused_o(vun), .single_ended_clock_o(sec), .diff_clkbuf_off_o(cbo),
    .unbalanced_input_a_o(ua), .unbalanced_input_b_o(ub), .sampling_half_period_o(h0),
    .offset_nulling_on_o(n0), .fuse_reload_o(frl));
  // fast variant only observed on the variant-dependent outputs
  scc_top #(.FAST_VARIANT(1'b1)) dut_fast (.core_clk_i(core_clk_i), .resetn_i(resetn_i),
    .sclk_i(sclk), .sen_n_i(sen_n), .sdio_i(sdio), .sdout_o(),
    .shared_align_powerdown_pin_i(pin_sh), .reference_buffer_pin_i(pin_rb),
    .global_powerdown_o(), .align_pulse_o(), .vref_source_o(), .vref_unused_o(),
    .single_ended_clock_o(), .diff_clkbuf_off_o(), .unbalanced_input_a_o(),
    .unbalanced_input_b_o(), .sampling_half_period_o(h1), .offset_nulling_on_o(n1),
    .fuse_reload_o());
  scc_host_model host (.core_clk_i(core_clk_i), .sclk_o(sclk), .sen_n_o(sen_n),
    .sdio_o(sdio), .sdout_i(sdout));

  // one-cycle pulses would be missed by polling, so count them here
  always @(posedge core_clk_i) begin
    if (algn === 1'b1) a_cnt++;
    if (frl === 1'b1) f_cnt++;
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      failures++;
    end
  endtask : chk

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] unused_rd;
    host.xfer(1'b0, a, d, unused_rd);
  endtask : wr

  task automatic rdchk(input logic [6:0] a, input logic [7:0] exp);
    host.xfer(1'b1, a, 8'h00, rd);
    chk(rd, exp);
  endtask : rdchk

  // pins pass a 3-flop filter, so allow well over its latency
  task automatic settle();
    repeat (12) @(posedge core_clk_i);
  endtask : settle

  task automatic t_reset();
    rdchk(SCC_OFS_SYNC_REF, 8'h00);
    rdchk(SCC_OFS_INPUT, 8'h00);
    rdchk(SCC_OFS_FUSE, 8'h00);
    chk({3'h0, pdn, algn, sec, n0, n1}, 8'h02);
  endtask : t_reset

  task automatic t_input();
    wr(SCC_OFS_INPUT, 8'h34);
    chk({4'h0, ua, ub, h0, h1}, 8'h0d);
    chk({6'h0, n0, n1}, 8'h02);
    wr(SCC_OFS_INPUT, 8'hcb);
    rdchk(SCC_OFS_INPUT, 8'h01);
    chk({2'h0, ua, ub, h0, h1, n0, n1}, 8'h01);
    rdchk(7'h20, 8'h00);
  endtask : t_input

  task automatic t_vref();
    logic [1:0] c;
    wr(SCC_OFS_SYNC_REF, 8'h07);
    pin_rb <= 1'b1;
    settle();
    chk({4'h0, vsrc, sec, cbo}, 8'h04);
    pin_rb <= 1'b0;
    settle();
    chk({6'h0, vsrc}, 8'h00);
    for (int i = 0; i < 4; i++) begin
      c = 2'(i);
      wr(SCC_OFS_SYNC_REF, {4'h0, 1'b1, c, c[0]});
      chk({3'h0, vun, vsrc, sec, cbo}, {3'h0, c == 2'h3, c, c[0], c[0]});
    end
  endtask : t_vref

  task automatic t_pin();
    wr(SCC_OFS_SYNC_REF, 8'h00);
    base = a_cnt;
    pin_sh <= 1'b1;
    settle();
    chk({7'h0, pdn}, 8'h01);
    pin_sh <= 1'b0;
    wr(SCC_OFS_SYNC_REF, 8'h80);
    pin_sh <= 1'b1;
    settle();
    chk({pdn, 7'(a_cnt - base)}, 8'h01);
    pin_sh <= 1'b0;
    wr(SCC_OFS_SYNC_REF, 8'ha0);
    pin_sh <= 1'b1;
    settle();
    chk(8'(a_cnt - base), 8'h01);
    pin_sh <= 1'b0;
  endtask : t_pin

  task automatic t_trig();
    wr(SCC_OFS_SYNC_REF, 8'h20);
    base = a_cnt;
    wr(SCC_OFS_SYNC_REF, 8'h60);
    chk(8'(a_cnt - base), 8'h01);
    wr(SCC_OFS_SYNC_REF, 8'h60);
    rdchk(SCC_OFS_SYNC_REF, 8'h60);
    wr(SCC_OFS_SYNC_REF, 8'h20);
    wr(SCC_OFS_SYNC_REF, 8'h60);
    chk(8'(a_cnt - base), 8'h02);
    wr(SCC_OFS_SYNC_REF, 8'h00);
    wr(SCC_OFS_SYNC_REF, 8'h40);
    chk(8'(a_cnt - base), 8'h02);
  endtask : t_trig

  task automatic t_fuse();
    wr(SCC_OFS_INPUT, 8'h30);
    wr(SCC_OFS_SYNC_REF, 8'h08);
    base = f_cnt;
    wr(SCC_OFS_FUSE, 8'hff);
    rdchk(SCC_OFS_FUSE, 8'h01);
    wr(SCC_OFS_FUSE, 8'h00);
    chk(8'(f_cnt - base), 8'h01);
    rdchk(SCC_OFS_INPUT, 8'h00);
    rdchk(SCC_OFS_SYNC_REF, 8'h00);
  endtask : t_fuse

  // a reset between frames must undo every register write and output
  task automatic t_rerun();
    wr(SCC_OFS_INPUT, 8'h35);
    wr(SCC_OFS_SYNC_REF, 8'h09);
    chk({ua, ub, h1, n0, n1, sec, cbo, 1'b0}, 8'hee);
    resetn_i <= 1'b0;
    repeat (3) @(posedge core_clk_i);
    resetn_i <= 1'b1;
    repeat (4) @(posedge core_clk_i);
    chk({ua, ub, h1, n0, n1, sec, cbo, 1'b0}, 8'h10);
    rdchk(SCC_OFS_INPUT, 8'h00);
    rdchk(SCC_OFS_SYNC_REF, 8'h00);
  endtask : t_rerun

  task automatic wrap_up();
    if (failures == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : wrap_up

  // main sequence
  initial begin
    repeat (10) @(posedge core_clk_i);
    resetn_i <= 1'b1;
    repeat (4) @(posedge core_clk_i);
    t_reset();
    t_input();
    t_vref();
    t_pin();
    t_trig();
    t_fuse();
    t_rerun();
    wrap_up();
  end

  // about 34 frames of 210 cycles are expected, so this is generous
  initial begin
    repeat (40000) @(posedge core_clk_i);
    failures++;
    wrap_up();
  end
endmodule : tb_converter_sync_ref_clock_config
